// ===== logic/dram_seq_pkg.sv
package dram_seq_pkg;

    // ------------------------------------------------------------
    // Sequencer timing in bus half-cycles (one ref_clk edge each), select rise counts, column bits and burst last word
    // ------------------------------------------------------------
    localparam logic [4:0] ROW_TO_COL_RCD0 = 5'h01;
    localparam logic [4:0] ROW_TO_CAS_RCD0 = 5'h02;
    localparam logic [4:0] ROW_TO_COL_RCD1 = 5'h03;
    localparam logic [4:0] ROW_TO_CAS_RCD1 = 5'h04;
    localparam logic [4:0] RAS_PRECHARGE_HALVES = 5'h04;
    localparam logic [4:0] ACK_LEAD_HALVES = 5'h08;
    localparam logic [4:0] CAS_PRECHARGE_CP0 = 5'h01;
    localparam logic [4:0] CAS_PRECHARGE_CP1 = 5'h03;
    localparam logic [1:0] ODD_RESTORE_HALVES = 2'h2;
    localparam logic [1:0] FAST_SELECT_RISES = 2'h1;
    localparam logic [1:0] SLOW_SELECT_RISES = 2'h2;
    localparam logic [3:0] MIN_COLUMN_BITS = 4'h9;
    localparam logic [2:0] BURST_LAST_WORD = 3'h3;

    // ------------------------------------------------------------
    // Bus master register map and fields, reset levels of byte enables and column strobes
    // ------------------------------------------------------------
    localparam logic [3:0] REG_ADDRESS = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_WRITE_BIT = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_BE_LSB = 4;
    localparam int STAT_WORDS_LSB = 4;
    localparam logic [3:0] RESET_BYTE_ENABLE_N = 4'hf;
    localparam logic [3:0] RESET_CAS_N = 4'hf;

endpackage : dram_seq_pkg

// ===== logic/dram_bus_if.sv
`timescale 1ns/1ps
interface dram_bus_if #(
    parameter int ADDR_W = 24,
    parameter int DRAM_ADDRESS_BUS_W = 12
);
    // ------------------------------------------------------------
    // CPU side of the multiplexed bus
    // ------------------------------------------------------------
    logic cpu_bus_clock;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic burst;
    logic [ADDR_W-1:0] addr;
    logic [3:0] byte_enable_n;
    logic ack_n;
    logic ack_oe;
    logic read_buffer_clock_enable_n;
    logic read_buffer_oe;

    // ------------------------------------------------------------
    // DRAM array and exchanger side
    // ------------------------------------------------------------
    logic exchanger_latch_enable;
    logic lane_steer;
    logic ras_even_n;
    logic ras_odd_n;
    logic [3:0] cas_n;
    logic [DRAM_ADDRESS_BUS_W-1:0] dram_address_bus;

    modport mem_ctrl (
        input cpu_bus_clock, cs_n, rd_n, wr_n, burst, addr, byte_enable_n,
        output ack_n, ack_oe, read_buffer_clock_enable_n, read_buffer_oe,
        output exchanger_latch_enable, lane_steer, ras_even_n, ras_odd_n, cas_n, dram_address_bus
    );

    modport cpu (
        output cpu_bus_clock, cs_n, rd_n, wr_n, burst, addr, byte_enable_n,
        input ack_n, ack_oe, read_buffer_clock_enable_n, read_buffer_oe,
        input exchanger_latch_enable, lane_steer, ras_even_n, ras_odd_n, cas_n, dram_address_bus
    );
endinterface : dram_bus_if

// ===== logic/cpu_bus_master.sv
`timescale 1ns/1ps
module cpu_bus_master #(
    parameter int ADDR_W = 24
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    dram_bus_if.cpu bus,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] target_addr;
    logic busy;
    logic [2:0] words;
    logic falling_tick;
    logic ack_seen;
    logic word_seen;
    logic finish;

    // Bus edge decode and completion
    always_comb begin
        falling_tick = bus.cpu_bus_clock;
        ack_seen = bus.ack_oe && !bus.ack_n;
        word_seen = bus.read_buffer_oe && !bus.read_buffer_clock_enable_n && bus.wr_n;
        finish = busy && falling_tick && (bus.burst ? (word_seen && words == dram_seq_pkg::BURST_LAST_WORD) : ack_seen);
    end

    // Bus clock divider, half period per ref_clk
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.cpu_bus_clock <= 1'b0;
        end else begin
            bus.cpu_bus_clock <= ~bus.cpu_bus_clock;
        end
    end

    // Address register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            target_addr <= '0;
        end else if (reg_wr && reg_addr == dram_seq_pkg::REG_ADDRESS) begin
            target_addr <= reg_wdata[ADDR_W-1:0];
        end
    end

    // Request launch and release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.cs_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.burst <= 1'b0;
            bus.addr <= '0;
            bus.byte_enable_n <= dram_seq_pkg::RESET_BYTE_ENABLE_N;
            busy <= 1'b0;
            words <= 3'h0;
        end else if (!busy && reg_wr && reg_addr == dram_seq_pkg::REG_CONTROL) begin
            bus.cs_n <= 1'b0;
            bus.rd_n <= reg_wdata[dram_seq_pkg::CTRL_WRITE_BIT];
            bus.wr_n <= ~reg_wdata[dram_seq_pkg::CTRL_WRITE_BIT];
            bus.burst <= reg_wdata[dram_seq_pkg::CTRL_BURST_BIT] & ~reg_wdata[dram_seq_pkg::CTRL_WRITE_BIT]; // see (RL4)
            bus.addr <= {target_addr[ADDR_W-1:3],
                         target_addr[2] & ~reg_wdata[dram_seq_pkg::CTRL_BURST_BIT], 2'h0}; // see (RL3)
            bus.byte_enable_n <= reg_wdata[dram_seq_pkg::CTRL_WRITE_BIT] ?
                                 reg_wdata[dram_seq_pkg::CTRL_BE_LSB +: 4] : 4'h0;
            busy <= 1'b1;
            words <= 3'h0;
        end else if (finish) begin
            bus.cs_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.burst <= 1'b0;
            busy <= 1'b0;
            words <= words + 3'h1;
        end else if (busy && falling_tick && word_seen) begin
            words <= words + 3'h1; // Words taken on falling edges
        end
    end

    // Register read port, data one cycle later
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                dram_seq_pkg::REG_ADDRESS: reg_rdata <= 32'(target_addr);
                dram_seq_pkg::REG_STATUS: reg_rdata <= {25'h0, words, 3'h0, busy};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule : cpu_bus_master

// ===== logic/interleaved_dram_burst_sequencer.sv
`timescale 1ns/1ps
// Function
// (RL1) Off-page write precharges rows, then re-multiplexes
// (RL2) Byte enables drive column strobes directly
// (RL3) Burst starts at even word, four words
// (RL4) Block flag with read starts burst
// (RL5) Rising edge: rows on, strobes enabled high
// (RL6) Fast delay: column fall, strobe rise, steer
// (RL7) Slow delay: column after 1.5 cycles
// (RL8) Column strobes drop on first-word edge
// (RL9) Same edge: latch closes, steer odd
// (RL10) Next falling edge: steer, latch back
// (RL11) After precharge: strobes again for pair two
// (RL12) Read enable one clock per word
// (RL13) Acknowledge four clocks before fourth word; at first column strobe when fewer half-cycles remain (width 00)
// (RL14) Burst end closes rows, leaves page
// (RL15) Rows drop half cycle after columns
// (RL16) Page hit: column now, strobes per select
// (RL17) Bursts only for cache misses
// (RL18) Width 01 is 1.5, precharge 0 is 0.5
// (RL19) Page hit by masked row compare
module interleaved_dram_burst_sequencer #(
    parameter int ADDR_W = 24,
    parameter int DRAM_ADDRESS_BUS_W = 12
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    dram_bus_if.mem_ctrl bus,
    input wire logic row_to_column_delay_sel,
    input wire logic [1:0] column_width_sel,
    input wire logic column_precharge_sel,
    input wire logic slow_select,
    input wire logic [1:0] page_size_sel,
    output logic page_open,
    output logic busy
);

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    localparam int WORD_W = ADDR_W - 2;

    typedef enum logic [6:0] {
        IDLE = 7'h01,
        PRE = 7'h02,
        ROW = 7'h04,
        HITW = 7'h08,
        CAS = 7'h10,
        GAP = 7'h20,
        CLOSE = 7'h40
    } state_type;

    function automatic logic [3:0] column_bits(input logic [1:0] sel);
        column_bits = dram_seq_pkg::MIN_COLUMN_BITS + {2'h0, sel};
    endfunction : column_bits

    function automatic logic [WORD_W-1:0] row_of(input logic [WORD_W-1:0] w, input logic [1:0] sel);
        row_of = w >> (column_bits(sel) + 4'h1);
    endfunction : row_of

    function automatic logic [WORD_W-1:0] col_of(input logic [WORD_W-1:0] w, input logic [1:0] sel);
        col_of = (w >> 1) & ~({WORD_W{1'b1}} << column_bits(sel));
    endfunction : col_of

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    state_type state;
    logic [4:0] cnt;
    logic [1:0] rises;
    logic pair;
    logic is_write;
    logic is_burst;
    logic [3:0] be_latch;
    logic [WORD_W-1:0] req_word;
    logic [WORD_W-1:0] open_word;
    logic [4:0] ack_cnt;
    logic [1:0] odd_cnt;

    logic rise_tick;
    logic req;
    logic [WORD_W-1:0] in_word;
    logic hit;
    logic [4:0] w_half;
    logic [4:0] p_half;
    logic [4:0] col_t;
    logic [4:0] cas_t;
    logic [4:0] lead;
    logic cas_start;
    logic cas_end;
    logic pre_word;
    logic start_row;
    logic start_hit;
    logic close_end;
    logic done;

    // Edge phase, timing selects and event strobes
    always_comb begin
        rise_tick = ~bus.cpu_bus_clock;
        req = ~bus.cs_n & (~bus.rd_n | ~bus.wr_n);
        in_word = bus.addr[ADDR_W-1:2];
        hit = page_open && (row_of(in_word, page_size_sel) == row_of(open_word, page_size_sel)); // see (RL19)
        w_half = {2'h0, column_width_sel, 1'b1}; // see (RL18)
        p_half = column_precharge_sel ? dram_seq_pkg::CAS_PRECHARGE_CP1 : dram_seq_pkg::CAS_PRECHARGE_CP0;
        col_t = row_to_column_delay_sel ? dram_seq_pkg::ROW_TO_COL_RCD1 : dram_seq_pkg::ROW_TO_COL_RCD0;
        cas_t = row_to_column_delay_sel ? dram_seq_pkg::ROW_TO_CAS_RCD1 : dram_seq_pkg::ROW_TO_CAS_RCD0;
        lead = {w_half[3:0], 1'b0} + p_half + 5'h02;
        cas_start = (state == ROW && cnt == cas_t) || (state == HITW && rise_tick && rises == 2'h1) ||
                    (state == GAP && cnt == p_half);
        cas_end = state == CAS && cnt == w_half;
        pre_word = (state == CAS && cnt == w_half - 5'h01) || (cas_start && w_half == 5'h01);
        start_row = state == PRE && rise_tick && cnt >= dram_seq_pkg::RAS_PRECHARGE_HALVES;
        start_hit = state == IDLE && req && hit;
        close_end = state == CLOSE && cnt == 5'h02;
        done = (cas_end && !is_burst) || close_end;
    end

    // ------------------------------------------------------------
    // Row and column strobe sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= IDLE;
            cnt <= 5'h00;
            rises <= 2'h0;
            pair <= 1'b0;
            is_write <= 1'b0;
            is_burst <= 1'b0;
            be_latch <= dram_seq_pkg::RESET_CAS_N;
            req_word <= '0;
            open_word <= '0;
            page_open <= 1'b0;
            busy <= 1'b0;
            bus.ras_even_n <= 1'b1;
            bus.ras_odd_n <= 1'b1;
            bus.cas_n <= dram_seq_pkg::RESET_CAS_N;
            bus.dram_address_bus <= '0;
        end else begin
            case (state)
                IDLE: if (req) begin
                    req_word <= in_word;
                    is_write <= ~bus.wr_n;
                    is_burst <= bus.wr_n & bus.burst; // see (RL4)
                    be_latch <= bus.wr_n ? 4'h0 : bus.byte_enable_n; // see (RL2)
                    busy <= 1'b1;
                    if (hit) begin
                        bus.dram_address_bus <= DRAM_ADDRESS_BUS_W'(col_of(in_word, page_size_sel)); // see (RL16)
                        rises <= slow_select ? dram_seq_pkg::SLOW_SELECT_RISES : dram_seq_pkg::FAST_SELECT_RISES;
                        state <= HITW;
                    end else begin
                        bus.ras_even_n <= 1'b1; // see (RL1)
                        bus.ras_odd_n <= 1'b1;
                        page_open <= 1'b0;
                        cnt <= page_open ? 5'h01 : dram_seq_pkg::RAS_PRECHARGE_HALVES;
                        state <= PRE;
                    end
                end
                PRE: if (start_row) begin
                    bus.ras_even_n <= 1'b0; // see (RL5)
                    bus.ras_odd_n <= 1'b0;
                    bus.dram_address_bus <= DRAM_ADDRESS_BUS_W'(row_of(req_word, page_size_sel));
                    open_word <= req_word;
                    page_open <= 1'b1;
                    cnt <= 5'h01;
                    state <= ROW;
                end else if (cnt < dram_seq_pkg::RAS_PRECHARGE_HALVES) begin
                    cnt <= cnt + 5'h01;
                end
                ROW: begin
                    cnt <= cnt + 5'h01;
                    if (cnt == col_t) begin
                        bus.dram_address_bus <= DRAM_ADDRESS_BUS_W'(col_of(req_word, page_size_sel)); // see (RL6) see (RL7)
                    end
                    if (cas_start) begin
                        bus.cas_n <= be_latch; // see (RL2)
                        cnt <= 5'h01;
                        state <= CAS;
                    end
                end
                HITW: if (rise_tick) begin
                    if (cas_start) begin
                        bus.cas_n <= be_latch; // see (RL16)
                        cnt <= 5'h01;
                        state <= CAS;
                    end else begin
                        rises <= rises - 2'h1;
                    end
                end
                CAS: if (cas_end) begin
                    bus.cas_n <= dram_seq_pkg::RESET_CAS_N; // see (RL8)
                    cnt <= 5'h01;
                    if (!is_burst) begin
                        state <= IDLE;
                        busy <= 1'b0;
                    end else if (!pair) begin
                        pair <= 1'b1;
                        state <= GAP;
                    end else begin
                        pair <= 1'b0;
                        state <= CLOSE;
                    end
                end else begin
                    cnt <= cnt + 5'h01;
                end
                GAP: if (cas_start) begin
                    bus.cas_n <= be_latch; // see (RL11)
                    cnt <= 5'h01;
                    state <= CAS;
                end else begin
                    cnt <= cnt + 5'h01;
                end
                CLOSE: begin
                    cnt <= cnt + 5'h01;
                    if (cnt == 5'h01) begin
                        bus.ras_even_n <= 1'b1; // see (RL14) see (RL15)
                        bus.ras_odd_n <= 1'b1;
                        page_open <= 1'b0;
                    end
                    if (close_end) begin
                        state <= IDLE;
                        busy <= 1'b0;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and read buffer enable
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.ack_n <= 1'b1;
            bus.ack_oe <= 1'b0;
            bus.read_buffer_clock_enable_n <= 1'b1;
            bus.read_buffer_oe <= 1'b0;
            ack_cnt <= 5'h00;
        end else if (start_row || start_hit) begin
            bus.ack_oe <= 1'b1; // see (RL5)
            bus.read_buffer_oe <= 1'b1;
            bus.ack_n <= 1'b1;
            bus.read_buffer_clock_enable_n <= 1'b1;
        end else if (done) begin
            bus.ack_n <= 1'b1;
            bus.ack_oe <= 1'b0;
            bus.read_buffer_clock_enable_n <= 1'b1;
            bus.read_buffer_oe <= 1'b0;
            ack_cnt <= 5'h00;
        end else begin
            // Half-cycles left until the fourth word
            if (cas_start && is_burst && !pair) begin
                ack_cnt <= lead - 5'h01;
                if (lead <= dram_seq_pkg::ACK_LEAD_HALVES) begin
                    bus.ack_n <= 1'b0; // see (RL13)
                end
            end else if (ack_cnt != 5'h00) begin
                ack_cnt <= ack_cnt - 5'h01;
                if (ack_cnt == dram_seq_pkg::ACK_LEAD_HALVES) begin
                    bus.ack_n <= 1'b0; // see (RL13)
                end
            end
            if (pre_word && !is_burst) begin
                bus.ack_n <= 1'b0;
            end
            if (pre_word && !is_write) begin
                bus.read_buffer_clock_enable_n <= 1'b0; // see (RL12)
            end else if (odd_cnt == dram_seq_pkg::ODD_RESTORE_HALVES && !(state == CAS && pair)) begin
                bus.read_buffer_clock_enable_n <= 1'b1; // see (RL12)
            end
        end
    end

    // ------------------------------------------------------------
    // Exchanger latch and lane steer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.lane_steer <= 1'b1;
            bus.exchanger_latch_enable <= 1'b1;
            odd_cnt <= 2'h0;
        end else begin
            // Second pair may start while the odd word is still held
            if (cas_start && odd_cnt == 2'h0) begin
                bus.lane_steer <= is_write ? ~req_word[0] : 1'b1; // see (RL6)
                bus.exchanger_latch_enable <= 1'b1;
            end
            if (cas_end && is_burst) begin
                bus.exchanger_latch_enable <= 1'b0; // see (RL9)
                bus.lane_steer <= 1'b0;
                odd_cnt <= 2'h1;
            end else if (odd_cnt == dram_seq_pkg::ODD_RESTORE_HALVES) begin
                bus.lane_steer <= 1'b1; // see (RL10)
                bus.exchanger_latch_enable <= 1'b1;
                odd_cnt <= 2'h0;
            end else if (odd_cnt != 2'h0) begin
                odd_cnt <= odd_cnt + 2'h1;
            end
        end
    end

endmodule : interleaved_dram_burst_sequencer

// ===== verification/dram_link_properties.sv
`timescale 1ns/1ps
module dram_link_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cpu_bus_clock,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic burst,
    input wire logic [3:0] byte_enable_n,
    input wire logic ack_n,
    input wire logic ack_oe,
    input wire logic read_buffer_clock_enable_n,
    input wire logic read_buffer_oe,
    input wire logic exchanger_latch_enable,
    input wire logic lane_steer,
    input wire logic ras_even_n,
    input wire logic ras_odd_n,
    input wire logic [3:0] cas_n
);
    // ------------------------------------------------------------
    // Link timing checks, one ref_clk edge per bus half-cycle
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    rows_paired_a: assert property (ras_even_n == ras_odd_n)
        else $error("row strobes differ");
    row_start_a: assert property (
        $fell(ras_even_n) |-> ack_oe && read_buffer_oe && ack_n && read_buffer_clock_enable_n)
        else $error("strobe enables not high at row start");
    lanes_follow_a: assert property (!wr_n && cas_n != 4'hf |-> cas_n == byte_enable_n)
        else $error("column strobes differ from byte enables");
    cas_on_rise_a: assert property (
        $past(cas_n) == 4'hf && cas_n != 4'hf |-> !$past(cpu_bus_clock))
        else $error("column strobe asserted off rising tick");
    cas_off_fall_a: assert property (
        $past(cas_n) != 4'hf && cas_n == 4'hf |-> $past(cpu_bus_clock))
        else $error("column strobe negated off falling tick");
    // Latch still closed on the odd word is exempt: the pair may restart early
    burst_open_a: assert property (
        !rd_n && burst && $past(cas_n) == 4'hf && cas_n != 4'hf && $past(exchanger_latch_enable)
        |-> lane_steer && exchanger_latch_enable)
        else $error("steer or latch low at burst column strobe");
    latch_hold_a: assert property (
        $fell(exchanger_latch_enable) |-> !lane_steer && cas_n == 4'hf
        && !read_buffer_clock_enable_n ##1 !exchanger_latch_enable && !read_buffer_clock_enable_n
        ##1 exchanger_latch_enable && lane_steer)
        else $error("latch and steer sequence wrong");
    rows_close_a: assert property (
        $rose(ras_even_n) && !exchanger_latch_enable
        |-> $past(cas_n) == 4'hf && $past(cas_n, 2) != 4'hf)
        else $error("rows not negated half cycle after columns");
    ack_lead_a: assert property (
        $rose(ras_even_n) && !exchanger_latch_enable
        |-> !$past(ack_n, 7) && $past(ack_n, 8))
        else $error("acknowledge not four clocks before last word");

    // Main scenarios reached
    cover property (burst && !rd_n && $fell(exchanger_latch_enable));
    cover property (!wr_n && cas_n != 4'hf && cas_n != 4'h0);
    cover property ($rose(ras_even_n) && exchanger_latch_enable);
endmodule : dram_link_checker

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic row_to_column_delay_sel = 1'b0;
    logic [1:0] column_width_sel = 2'h1;
    logic column_precharge_sel = 1'b0;
    logic slow_select = 1'b0;
    logic [1:0] page_size_sel = 2'h0;
    logic page_open;
    logic seq_busy;
    logic [31:0] rd_val;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int ras_fall = 0;
    int ras_rise = 0;
    int f;
    int r;

    dram_bus_if bus ();
    cpu_bus_master i_cpu_bus_master (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    interleaved_dram_burst_sequencer i_interleaved_dram_burst_sequencer (.ref_clk(ref_clk), .arst_n(arst_n),
        .bus(bus), .row_to_column_delay_sel(row_to_column_delay_sel), .column_width_sel(column_width_sel),
        .column_precharge_sel(column_precharge_sel), .slow_select(slow_select),
        .page_size_sel(page_size_sel), .page_open(page_open), .busy(seq_busy));
    dram_link_checker i_dram_link_checker (.ref_clk(ref_clk), .arst_n(arst_n),
        .cpu_bus_clock(bus.cpu_bus_clock), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .burst(bus.burst),
        .byte_enable_n(bus.byte_enable_n), .ack_n(bus.ack_n), .ack_oe(bus.ack_oe),
        .read_buffer_clock_enable_n(bus.read_buffer_clock_enable_n), .read_buffer_oe(bus.read_buffer_oe),
        .exchanger_latch_enable(bus.exchanger_latch_enable), .lane_steer(bus.lane_steer),
        .ras_even_n(bus.ras_even_n), .ras_odd_n(bus.ras_odd_n), .cas_n(bus.cas_n));

    // ------------------------------------------------------------
    // Clock, timeout and row strobe counters
    // ------------------------------------------------------------
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // Count row openings and closings
    always @(negedge bus.ras_even_n) if (arst_n) ras_fall++;
    always @(posedge bus.ras_even_n) if (arst_n) ras_rise++;

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Start one transfer and poll until done, bounded
    task automatic run(input logic [23:0] a, input logic [7:0] ctrl);
        int n;
        reg_write(dram_seq_pkg::REG_ADDRESS, {8'h00, a});
        reg_write(dram_seq_pkg::REG_CONTROL, {24'h0, ctrl});
        n = 0;
        rd_val = 32'h1;
        while (rd_val[0] !== 1'b0 && n < 400) begin
            reg_read(dram_seq_pkg::REG_STATUS, rd_val);
            n++;
        end
        repeat (8) @(posedge ref_clk);
    endtask : run

    // ------------------------------------------------------------
    // Main sequence: two timing sets, burst then writes
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        reg_read(dram_seq_pkg::REG_STATUS, rd_val);
        compare(rd_val, 32'h0);
        reg_read(4'hc, rd_val);
        compare(rd_val, 32'h0);
        for (int i = 0; i < 2; i++) begin
            row_to_column_delay_sel <= i[0];
            column_width_sel <= i[0] ? 2'h2 : 2'h1;
            column_precharge_sel <= i[0];
            slow_select <= i[0];
            page_size_sel <= {i[0], i[0]};
            run(24'h000100, 8'h02);
            compare(rd_val & 32'h71, 32'h40);
            compare({31'h0, page_open}, 32'h0);
            f = ras_fall;
            run(24'h000200, 8'h51);
            compare(32'(ras_fall - f), 32'h1);
            compare({31'h0, page_open}, 32'h1);
            run(24'h000204, 8'ha1);
            compare(32'(ras_fall - f), 32'h1);
            r = ras_rise;
            run(24'h800000, 8'h01);
            compare(32'(ras_rise - r), 32'h1);
            compare(32'(ras_fall - f), 32'h2);
            // Page hit burst: rows stay low until the end
            run(24'h800010, 8'h02);
            compare(rd_val & 32'h71, 32'h40);
            compare(32'(ras_fall - f), 32'h2);
            compare({31'h0, page_open}, 32'h0);
        end
        finish_test();
    end
endmodule : testbench
